/* design/slvd_top.sv */
// supply low-voltage detector: control register, flag, interrupt, axi4-lite slave
// assumes comparator outputs are asynchronous, high while the input is below reference
`timescale 1ns/1ns
`default_nettype none
module slvd_top
#(
  parameter int REF_CYC = slvd_pkg::SLVD_REF_CYC
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [3:0] awaddr,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [3:0] araddr,
  // axi4-lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // analog side
  input wire logic tap_below_ref,
  input wire logic external_trip_input,
  output logic [3:0] tap_select,
  output logic ext_route,
  output logic detector_power_enable,
  // interrupt
  output logic irq
);
  import slvd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0] trip_select_r;
  logic en_r;
  logic reference_stable_r;
  logic [7:0] settle_r;
  logic [SLVD_NEV-1:0] stat_r;
  logic [SLVD_NEV-1:0] ien_r;
  logic [3:0] awaddr_r;
  logic aw_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic w_have_r;

  //////////////////////////////////////////////////////////////////////////////
  // comparator path
  logic tap_sync;
  logic ext_sync;
  slvd_sync u_sync_tap
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(tap_below_ref),
    .q(tap_sync)
  );
  slvd_sync u_sync_ext
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(external_trip_input),
    .q(ext_sync)
  );

  wire ext_mode = (trip_select_r == SLVD_SEL_EXT);
  // pin compared against reference in external mode
  wire below = ext_mode ? ext_sync : tap_sync;
  // no flag until enabled and reference settled, so stale compare is ignored
  wire low_ev = below & en_r & reference_stable_r;
  wire ref_ev = en_r & ~reference_stable_r & (settle_r == 8'(REF_CYC - 1));

  //////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire do_write = aw_have_r & w_have_r & ~bvalid;
  wire wr_ctrl = do_write & (awaddr_r[3:2] == SLVD_CTRL_OFS[3:2]) & wstrb_r[0];
  wire wr_ien = do_write & (awaddr_r[3:2] == SLVD_IEN_OFS[3:2]) & wstrb_r[0];
  wire wr_iclr = do_write & (awaddr_r[3:2] == SLVD_ICLR_OFS[3:2]) & wstrb_r[0];
  wire [SLVD_NEV-1:0] ev = {ref_ev, low_ev};
  wire [SLVD_NEV-1:0] clr = wr_iclr ? wdata_r[SLVD_NEV-1:0] : '0;
  // set wins over a clear in the same cycle
  wire [SLVD_NEV-1:0] stat_nxt = (stat_r & ~clr) | ev;
  wire [7:0] ctrl_rd = {2'b00, reference_stable_r, en_r, trip_select_r};
  wire [31:0] rd_nxt =
    (araddr[3:2] == SLVD_CTRL_OFS[3:2]) ? {24'h0, ctrl_rd} :
    (araddr[3:2] == SLVD_STAT_OFS[3:2]) ? {30'h0, stat_r} :
    (araddr[3:2] == SLVD_IEN_OFS[3:2]) ? {30'h0, ien_r} : 32'h0;
  wire rd_take = arvalid & arready;

  //////////////////////////////////////////////////////////////////////////////
  // control register and settle counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trip_select_r <= SLVD_SEL_RST;
      en_r <= SLVD_EN_RST;
    end
    else if (wr_ctrl)
    begin
      trip_select_r <= wdata_r[SLVD_SEL_LSB +: SLVD_SEL_W];
      en_r <= wdata_r[SLVD_EN_BIT];
    end
  end

  // reference stable only after settle time with power on
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en_r)
    begin
      settle_r <= 8'h0;
      reference_stable_r <= 1'b0;
    end
    else if (!reference_stable_r)
    begin
      settle_r <= settle_r + 8'h1;
      reference_stable_r <= ref_ev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status, enable and interrupt
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_r <= '0;
      ien_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      if (wr_ien)
        ien_r <= wdata_r[SLVD_NEV-1:0];
      irq <= |(stat_nxt & (wr_ien ? wdata_r[SLVD_NEV-1:0] : ien_r));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tap_select <= SLVD_SEL_RST;
      ext_route <= 1'b0;
      detector_power_enable <= SLVD_EN_RST;
    end
    else
    begin
      tap_select <= trip_select_r;
      ext_route <= ext_mode;
      detector_power_enable <= en_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data held until both present
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= SLVD_RESP_OK;
    end
    else
    begin
      awready <= ~aw_have_r & ~(awvalid & awready) & ~bvalid;
      wready <= ~w_have_r & ~(wvalid & wready) & ~bvalid;
      if (awvalid && awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (do_write)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        // status is read only
        bresp <= (awaddr_r[3:2] == SLVD_STAT_OFS[3:2]) ? SLVD_RESP_SLVERR : SLVD_RESP_OK;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= SLVD_RESP_OK;
    end
    else
    begin
      arready <= ~rvalid & ~rd_take;
      if (rd_take)
      begin
        rvalid <= 1'b1;
        rdata <= rd_nxt;
        rresp <= (araddr[3:2] == SLVD_ICLR_OFS[3:2]) ? SLVD_RESP_SLVERR : SLVD_RESP_OK;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule : slvd_top
`default_nettype wire

/* design/slvd_pkg.sv */
// constants, register map and field layout of the supply low-voltage detector
// assumes a 250 MHz aclk and an AXI4-Lite master with 32-bit data
//
// What this block does
// - set low flag when supply below trip
// - enabled low flag raises interrupt request
// - flag sets when tap crosses below reference
// - four-bit trip select in control bits 3:0
// - select all ones routes external pin
// - external mode: flag when pin below reference
// - software power enable; off means no flag
// - control bits 7:6 read zero, ignore writes
// - reference stable bit shows detector readiness
package slvd_pkg;
  // register byte offsets
  localparam logic [3:0] SLVD_CTRL_OFS = 4'h0;
  localparam logic [3:0] SLVD_STAT_OFS = 4'h4;
  localparam logic [3:0] SLVD_IEN_OFS = 4'h8;
  localparam logic [3:0] SLVD_ICLR_OFS = 4'hc;
  // control register fields
  localparam int SLVD_SEL_LSB = 0;
  localparam int SLVD_SEL_W = 4;
  localparam int SLVD_EN_BIT = 4;
  localparam int SLVD_RST_BIT = 5;
  localparam logic [3:0] SLVD_SEL_EXT = 4'hf;
  // reset values of the control register
  localparam logic [3:0] SLVD_SEL_RST = 4'h5;
  localparam logic SLVD_EN_RST = 1'b0;
  // status bits: 0 supply low, 1 reference became stable
  localparam int SLVD_NEV = 2;
  localparam int SLVD_EV_LOW = 0;
  localparam int SLVD_EV_REF = 1;
  // axi responses
  localparam logic [1:0] SLVD_RESP_OK = 2'h0;
  localparam logic [1:0] SLVD_RESP_SLVERR = 2'h2;
  // reference settling time after power enable
  localparam int SLVD_REF_SETTLE_NS = 20;
  localparam int SLVD_CLK_MHZ = 250;
  localparam int SLVD_REF_CYC = (SLVD_REF_SETTLE_NS * SLVD_CLK_MHZ + 999) / 1000;
endpackage : slvd_pkg

/* design/slvd_sync.sv */
// two-flop level synchroniser
// assumes an asynchronous single-bit input
`timescale 1ns/1ns
`default_nettype none
module slvd_sync
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // level in and out
  input wire logic d,
  output logic q
);
  logic meta_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : slvd_sync
`default_nettype wire

/* test/slvd_props.sv */
// checker for the detector's bus handshakes and trip select outputs
// assumes binding to slvd_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module slvd_props
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // detector
  input wire logic [3:0] tap_select,
  input wire logic ext_route,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_ext_sel: assert property ($stable(tap_select) |-> ext_route == (tap_select == 4'hf))
    else $error("ext route disagrees with select");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  // both halves are latched first, so the response comes two cycles after the take
  a_b_after: assert property (awvalid && awready && wvalid && wready |=> ##1 bvalid)
    else $error("write response late");
  a_r_after: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_aw_gap: assert property (awvalid && awready |=> !awready)
    else $error("write address taken twice");
  a_ar_gap: assert property (arvalid && arready |=> !arready)
    else $error("read address taken twice");
  a_b_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  // main scenarios reached
  c_ext_irq: cover property (irq && ext_route);
  c_slverr: cover property (bvalid && bresp == 2'h2);
  c_irq_rise: cover property ($rose(irq));
endmodule : slvd_props
`default_nettype wire

/* test/slvd_top_tb.sv */
// self-checking bench for the supply low-voltage detector
// assumes slvd_top and its package; wstrb tied to all lanes
`timescale 1ns/1ns
`default_nettype none
module slvd_top_tb;
  import slvd_pkg::*;
  localparam int RC = 5;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tap_below_ref, external_trip_input;
  logic ext_route, detector_power_enable, irq;
  logic [3:0] awaddr, araddr, tap_select;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  int fails, checked;
  // write data, expected read back; bit 4 kept low here
  logic [15:0] rows [4] = '{16'hcf0f, 16'h2a0a, 16'he000, 16'h4303};
  slvd_top #(.REF_CYC(RC)) slvd_top_inst (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .tap_below_ref,
    .external_trip_input, .tap_select, .ext_route, .detector_power_enable, .irq);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] o);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    o = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] o);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    o = rresp;
    rready <= 1'b0;
  endtask : rd
  // comparator event, then release and clear; sync needs the settle waits
  task automatic trip(input logic t, input logic x, input logic [31:0] f, input logic e);
    tap_below_ref <= t;
    external_trip_input <= x;
    repeat (6) @(posedge aclk);
    chk(irq, e);
    rd(SLVD_STAT_OFS, d, r);
    chk(d, f);
    tap_below_ref <= 1'b0;
    external_trip_input <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(SLVD_ICLR_OFS, 32'h3, r);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
  endtask : trip
  task automatic results();
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    #100000;
    fails++;
    results();
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, tap_below_ref, external_trip_input} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    aresetn = 1'b0;
    fails = 0;
    checked = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(SLVD_CTRL_OFS, d, r);
    chk(d, 32'h5);
    foreach (rows[i])
    begin
      wr(SLVD_CTRL_OFS, 32'(rows[i][15:8]), r);
      rd(SLVD_CTRL_OFS, d, r);
      chk(d, 32'(rows[i][7:0]));
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(SLVD_CTRL_OFS, 32'(i), r);
      repeat (2) @(posedge aclk);
      chk({tap_select, ext_route}, {i[3:0], i == 15});
    end
    wr(SLVD_STAT_OFS, 32'h0, r);
    chk(r, SLVD_RESP_SLVERR);
    rd(SLVD_ICLR_OFS, d, r);
    chk(r, SLVD_RESP_SLVERR);
    wr(SLVD_CTRL_OFS, 32'h14, r);
    repeat (RC + 4) @(posedge aclk);
    rd(SLVD_CTRL_OFS, d, r);
    chk(d, 32'h34);
    wr(SLVD_IEN_OFS, 32'h0, r);
    trip(1'b1, 1'b0, 32'h3, 1'b0);
    wr(SLVD_IEN_OFS, 32'h1, r);
    rd(SLVD_IEN_OFS, d, r);
    chk(d, 32'h1);
    chk(r, SLVD_RESP_OK);
    trip(1'b1, 1'b0, 32'h1, 1'b1);
    wr(SLVD_CTRL_OFS, 32'h1f, r);
    trip(1'b1, 1'b0, 32'h0, 1'b0);
    trip(1'b0, 1'b1, 32'h1, 1'b1);
    wr(SLVD_CTRL_OFS, 32'h0f, r);
    trip(1'b0, 1'b1, 32'h0, 1'b0);
    chk(detector_power_enable, 1'b0);
    rd(SLVD_CTRL_OFS, d, r);
    chk(d, 32'h0f);
    results();
  end
endmodule : slvd_top_tb
bind slvd_top slvd_props slvd_props_inst (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
  .tap_select, .ext_route, .irq);
`default_nettype wire
